// *** inc/srsd_pkg.sv ***
package srsd_pkg;

  // ----------------------------------------
  // Field widths
  // ----------------------------------------
  localparam int STEP_CODE_W = 4;
  localparam int WIDTH_CODE_W = 3;
  localparam int LANE_CODE_W = 3;
  localparam int TYPE_CODE_W = 2;
  localparam int ELEM_W = 6;

  // ----------------------------------------
  // Row step codes
  // ----------------------------------------
  localparam logic [3:0] STEP_0 = 4'h0;
  localparam logic [3:0] STEP_1 = 4'h1;
  localparam logic [3:0] STEP_2 = 4'h2;
  localparam logic [3:0] STEP_4 = 4'h3;
  localparam logic [3:0] STEP_8 = 4'h4;
  localparam logic [3:0] STEP_16 = 4'h5;
  localparam logic [3:0] STEP_32 = 4'h6;
  localparam logic [3:0] STEP_MULTI = 4'hf;

  // ----------------------------------------
  // Region width codes, 101..111 reserved
  // ----------------------------------------
  localparam logic [2:0] WIDTH_MAX_CODE = 3'h4;

  // ----------------------------------------
  // Element types
  // ----------------------------------------
  localparam logic [1:0] TYPE_BYTE = 2'h0;
  localparam logic [1:0] TYPE_WORD = 2'h1;
  localparam logic [1:0] TYPE_DWORD = 2'h2;
  localparam logic [1:0] TYPE_QWORD = 2'h3;

  // Register pair limit in bytes
  localparam int REGION_BYTES = 64;

  // ----------------------------------------
  // Bus register map
  // ----------------------------------------
  localparam logic [11:0] OFS_OPERAND = 12'h000;
  localparam logic [11:0] OFS_RESULT = 12'h004;
  localparam logic [11:0] OFS_COUNT = 12'h008;

  // Operand word bit positions
  localparam int POS_STEP = 0;
  localparam int POS_WIDTH = 4;
  localparam int POS_LANE = 7;
  localparam int POS_TYPE = 10;
  localparam int POS_INDIRECT = 12;
  localparam int POS_QUAD = 13;
  localparam int POS_SECOND = 14;
  localparam int POS_DEST = 15;
  localparam int POS_IMM = 16;
  localparam int POS_SUBREG = 17;

  localparam logic [31:0] OPERAND_RST = 32'h0000_0000;

  typedef struct packed {
    logic [2:0] subreg;
    logic is_imm;
    logic is_dest;
    logic second_source;
    logic quad_aligned_access;
    logic addressing_select;
    logic [1:0] elem_type;
    logic [2:0] lane_count;
    logic [2:0] width_code;
    logic [3:0] row_step_code;
  } srsd_operand_type;

  typedef struct packed {
    logic illegal;
    logic step_present;
    logic multi_index_row_mode;
    logic [2:0] width_bad;
    logic [5:0] row_step;
    logic [4:0] width_elems;
    logic [4:0] index_count;
  } srsd_result_type;

endpackage

// *** rtl/srsd_decoder.sv ***
// Behaviour
// - Row step in elements comes from a four-bit source operand field.
// - Codes 0 to 4 give steps 0, 1, 2, 4 and 8.
// - Step 16 (code 5) is legal only for byte or word elements.
// - Step 32 is legal only for byte elements.
// - Codes 7 to 14 are reserved; no step beyond 32.
// - A source region stays within two adjacent registers, 64 bytes; the code bounds only one step plus one row, and not in multi-index mode.
// - Code 15 is multi-index mode, legal only indirect and element-aligned.
// - Multi-index uses lane count divided by width address sub-registers.
// - The row step is decoded for source operands only, never destination.
// - An immediate source has no row step field.
// - Quad-aligned access accepts only codes 0 and 3.
// - Quad-aligned indirect access supports a single address index only.
// - Second source indirect access refuses code 15, single index only.
// - A three-bit field gives elements per row.
// - Width above the lane count is flagged illegal.
module srsd_decoder (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hsel,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic illegal_r,
  output logic multi_index_row_mode_r
);

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  logic wr_pend_r;
  logic op_new_r;
  logic [11:0] addr_r;
  logic [31:0] operand_r;
  logic [15:0] count_r;
  logic [31:0] rd_word;
  srsd_pkg::srsd_result_type res_r;
  srsd_pkg::srsd_result_type res_nxt;
  srsd_pkg::srsd_operand_type op;
  logic take;
  logic wr_operand;
  logic wr_count;

  assign take = hsel && hready && htrans[1];
  assign op = operand_r[19:0];

  // ----------------------------------------
  // Address phase
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_pend_r <= 1'b0;
      addr_r <= 12'h000;
    end else if (hready) begin
      wr_pend_r <= take && hwrite;
      addr_r <= haddr;
    end
  end

  // Data phase writes, decoded from the held address
  assign wr_operand = wr_pend_r && addr_r == srsd_pkg::OFS_OPERAND;
  assign wr_count = wr_pend_r && addr_r == srsd_pkg::OFS_COUNT;

  // Response always OKAY, zero wait state
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ----------------------------------------
  // Operand register
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      operand_r <= srsd_pkg::OPERAND_RST;
    end else if (wr_operand) begin
      operand_r <= {12'h000, hwdata[19:0]};
    end
  end

  // Decode lags the write by one cycle; count only then
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      op_new_r <= 1'b0;
    end else begin
      op_new_r <= wr_operand;
    end
  end

  // ----------------------------------------
  // Illegal counter
  // ----------------------------------------
  // Any write to OFS_COUNT clears; clear wins over a count in the same cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_r <= 16'h0000;
    end else if (wr_count) begin
      count_r <= 16'h0000;
    end else if (op_new_r && res_nxt.illegal) begin
      count_r <= count_r + 16'h0001;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_comb begin
    case (haddr)
      srsd_pkg::OFS_OPERAND: rd_word = operand_r;
      srsd_pkg::OFS_RESULT: rd_word = {10'h000, res_r};
      srsd_pkg::OFS_COUNT: rd_word = {16'h0000, count_r};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Loaded in the address phase so hrdata is a flop
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      hrdata <= rd_word;
    end
  end

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  logic [4:0] lanes;
  logic [4:0] width_elems;
  logic [3:0] elem_bytes;
  logic [5:0] step_elems;
  logic [4:0] index_count;
  logic [9:0] span;
  logic step_present;
  logic multi_sel;
  logic code_ok;
  logic type_ok;
  logic quad_ok;
  logic multi_ok;
  logic step_ok;
  logic width_ok;
  logic lanes_ok;
  logic span_ok;

  // ----------------------------------------
  // Field presence
  // ----------------------------------------
  // Destination and immediate carry no step field
  assign step_present = !op.is_dest && !op.is_imm;

  // ----------------------------------------
  // Row step code
  // ----------------------------------------
  always_comb begin
    step_elems = 6'h00;
    multi_sel = 1'b0;
    code_ok = 1'b1;
    case (op.row_step_code)
      srsd_pkg::STEP_0: step_elems = 6'h00;
      srsd_pkg::STEP_1: step_elems = 6'h01;
      srsd_pkg::STEP_2: step_elems = 6'h02;
      srsd_pkg::STEP_4: step_elems = 6'h04;
      srsd_pkg::STEP_8: step_elems = 6'h08;
      srsd_pkg::STEP_16: step_elems = 6'h10;
      srsd_pkg::STEP_32: step_elems = 6'h20;
      srsd_pkg::STEP_MULTI: multi_sel = 1'b1;
      // Steps past 32 would leave the register pair
      default: code_ok = 1'b0;
    endcase
  end

  // Wide elements push long steps past the pair
  always_comb begin
    case (op.row_step_code)
      srsd_pkg::STEP_16: begin
        type_ok = op.elem_type == srsd_pkg::TYPE_BYTE ||
                  op.elem_type == srsd_pkg::TYPE_WORD;
      end
      srsd_pkg::STEP_32: type_ok = op.elem_type == srsd_pkg::TYPE_BYTE;
      default: type_ok = 1'b1;
    endcase
  end

  // ----------------------------------------
  // Access mode and indirect checks
  // ----------------------------------------
  always_comb begin
    quad_ok = 1'b1;
    if (op.quad_aligned_access) begin
      case (op.row_step_code)
        srsd_pkg::STEP_0: quad_ok = 1'b1;
        srsd_pkg::STEP_4: quad_ok = 1'b1;
        default: quad_ok = 1'b0;
      endcase
    end
  end

  // One index per row needs the indirect address register
  always_comb begin
    multi_ok = 1'b1;
    if (multi_sel) begin
      multi_ok = op.addressing_select;
      if (op.quad_aligned_access) begin
        multi_ok = 1'b0;
      end
      if (op.second_source) begin
        multi_ok = 1'b0;
      end
    end
  end

  // Every check must pass for the step to be usable
  always_comb begin
    step_ok = 1'b1;
    if (!code_ok) begin
      step_ok = 1'b0;
    end
    if (!type_ok) begin
      step_ok = 1'b0;
    end
    if (!quad_ok) begin
      step_ok = 1'b0;
    end
    if (!multi_ok) begin
      step_ok = 1'b0;
    end
  end

  // ----------------------------------------
  // Lane count and region width
  // ----------------------------------------
  // Lane codes above 4 (over 16 lanes) do not fit five bits and read as zero
  always_comb begin
    case (op.lane_count)
      3'h0: lanes = 5'h01;
      3'h1: lanes = 5'h02;
      3'h2: lanes = 5'h04;
      3'h3: lanes = 5'h08;
      3'h4: lanes = 5'h10;
      default: lanes = 5'h00;
    endcase
  end

  always_comb begin
    width_ok = op.width_code <= srsd_pkg::WIDTH_MAX_CODE;
    case (op.width_code)
      3'h0: width_elems = 5'h01;
      3'h1: width_elems = 5'h02;
      3'h2: width_elems = 5'h04;
      3'h3: width_elems = 5'h08;
      3'h4: width_elems = 5'h10;
      default: width_elems = 5'h00;
    endcase
  end

  // Width may not exceed the lanes of the instruction
  assign lanes_ok = !width_ok || width_elems <= lanes;

  // ----------------------------------------
  // Register pair span
  // ----------------------------------------
  always_comb begin
    case (op.elem_type)
      srsd_pkg::TYPE_BYTE: elem_bytes = 4'h1;
      srsd_pkg::TYPE_WORD: elem_bytes = 4'h2;
      srsd_pkg::TYPE_DWORD: elem_bytes = 4'h4;
      srsd_pkg::TYPE_QWORD: elem_bytes = 4'h8;
      default: elem_bytes = 4'h1;
    endcase
  end

  // Rough bound: one step plus one row, exact only for two rows
  assign span = ({4'h0, step_elems} + {5'h00, width_elems}) * {6'h00, elem_bytes};
  // Multi-index rows start anywhere, so the bound does not apply
  assign span_ok = multi_sel || span <= 10'(srsd_pkg::REGION_BYTES);

  // ----------------------------------------
  // Address index count
  // ----------------------------------------
  always_comb begin
    index_count = 5'h01;
    if (multi_sel && width_ok) begin
      index_count = 5'(lanes >> op.width_code);
    end
  end

  // ----------------------------------------
  // Result word
  // ----------------------------------------
  always_comb begin
    res_nxt = '0;
    res_nxt.step_present = step_present;
    res_nxt.width_elems = width_elems;
    res_nxt.width_bad[0] = !width_ok;
    res_nxt.width_bad[1] = !lanes_ok;
    res_nxt.width_bad[2] = !span_ok;
    // Absent field: never illegal, step outputs stay zero
    res_nxt.illegal = step_present && (!step_ok || !width_ok || !lanes_ok || !span_ok);
    if (step_present) begin
      res_nxt.row_step = step_elems;
      res_nxt.multi_index_row_mode = multi_sel;
      res_nxt.index_count = index_count;
    end
  end

  // ----------------------------------------
  // Result registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      res_r <= '0;
    end else begin
      res_r <= res_nxt;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      illegal_r <= 1'b0;
    end else begin
      illegal_r <= res_nxt.illegal;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      multi_index_row_mode_r <= 1'b0;
    end else begin
      multi_index_row_mode_r <= res_nxt.multi_index_row_mode;
    end
  end

endmodule // srsd_decoder

// *** verif/srsd_checker.sv ***
module srsd_checker (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hsel,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic illegal_r,
  input wire logic multi_index_row_mode_r
);
  // ------
  // Data phase of an operand write
  // ------
  logic wp_r;
  logic q;
  logic [3:0] c;
  logic [31:0] w;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wp_r <= 1'b0;
    end else begin
      wp_r <= hsel && hready && htrans[1] && hwrite && haddr == srsd_pkg::OFS_OPERAND;
    end
  end
  assign w = hwdata;
  assign c = w[3:0];
  assign q = wp_r && !w[15] && !w[16];
  // Cause taken with the data; flags land two edges later
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_step_reserved: assert property (q && c > 4'h6 && c < 4'hf |-> ##2 illegal_r)
    else $error("reserved step passed");
  a_step16_type: assert property (q && c == 4'h5 && w[11:10] > 2'h1 |-> ##2 illegal_r)
    else $error("step 16 wide type passed");
  a_step32_type: assert property (q && c == 4'h6 && w[11:10] != 2'h0 |-> ##2 illegal_r)
    else $error("step 32 wide type passed");
  a_quad_codes: assert property (q && w[13] && c != 4'h0 && c != 4'h3 |-> ##2 illegal_r)
    else $error("quad code passed");
  a_multi_guard: assert property (q && c == 4'hf && (!w[12] || w[14]) |-> ##2 illegal_r)
    else $error("multi guard missed");
  a_width_lanes: assert property (
    q && (w[6:4] > 3'h4 || (w[9:7] < 3'h5 && w[6:4] > w[9:7])) |-> ##2 illegal_r)
    else $error("width passed");
  a_multi_decode: assert property (q && c == 4'hf |-> ##2 multi_index_row_mode_r)
    else $error("multi not set");
  a_multi_off: assert property (wp_r && c != 4'hf |-> ##2 !multi_index_row_mode_r)
    else $error("multi set");
  a_field_absent: assert property (
    wp_r && (w[15] || w[16]) |-> ##2 !illegal_r && !multi_index_row_mode_r)
    else $error("absent field decoded");
endmodule // srsd_checker

bind srsd_decoder srsd_checker chk (.clk, .reset_n, .haddr, .htrans, .hwrite, .hsel, .hready,
  .hwdata, .illegal_r, .multi_index_row_mode_r);

// *** verif/tb_source_region_stride_decode.sv ***
module tb_source_region_stride_decode;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [11:0] haddr = 12'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic illegal_r;
  logic multi;
  int fails = 0;
  int samples_checked = 0;
  int cyc = 0;
  int n_ill = 0;
  srsd_decoder dut (.clk, .reset_n, .haddr, .htrans, .hwrite, .hsize(3'h2), .hsel(1'b1),
    .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp,
    .illegal_r, .multi_index_row_mode_r(multi));
  initial forever #50 clk = ~clk;
  // ------
  // Checks and bus
  // ------
  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x) begin
      fails++;
      $display("MISMATCH %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic chk_flag(input logic g, input logic x);
    chk_word({31'h0, g}, {31'h0, x});
  endtask
  task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r);
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  // Returns illegal and multi-index flags
  function automatic logic [1:0] expect_of(input logic [31:0] w);
    int c;
    int st;
    int wd;
    int ln;
    logic bad;
    if (w[15] | w[16]) return 2'b00;
    c = w[3:0];
    st = (c == 0) ? 0 : (1 << (c - 1));
    wd = 1 << w[6:4];
    ln = (1 << w[9:7]) & 31;
    bad = (c > 6 && c < 15) || w[6:4] > 4 || wd > ln || (c == 5 && w[11:10] > 1)
      || (c == 6 && w[11:10] != 0) || (w[13] && c != 0 && c != 3)
      || (c == 15 && (!w[12] || w[13] || w[14]))
      || (c != 15 && (st + wd) * (1 << w[11:10]) > 64);
    return {bad, c == 15};
  endfunction
  task automatic try(input logic [31:0] w);
    logic [31:0] r;
    logic [1:0] e;
    e = expect_of(w);
    ahb(1'b1, srsd_pkg::OFS_OPERAND, w, r);
    @(posedge clk);
    #1;
    chk_flag(illegal_r, e[1]);
    chk_flag(multi, e[0]);
    chk_flag(hresp, 1'b0);
    @(posedge clk);
    ahb(1'b0, srsd_pkg::OFS_RESULT, 32'h0, r);
    chk_flag(r[21], e[1]);
    chk_flag(r[20], !(w[15] | w[16]));
    if (e == 2'b01) chk_word({27'h0, r[4:0]}, 32'((1 << w[9:7]) >> w[6:4]));
    ahb(1'b0, srsd_pkg::OFS_OPERAND, 32'h0, r);
    chk_word({12'h0, r[19:0]}, {12'h0, w[19:0]});
    n_ill += e[1];
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 6000) begin
      fails++;
      test_done();
    end
  end
  initial begin
    logic [31:0] r;
    logic [31:0] cs[12] = '{32'h985, 32'h586, 32'h2183, 32'h2181, 32'h318f, 32'h518f,
      32'h8189, 32'h10189, 32'h140, 32'h1d0, 32'h122f, 32'ha44};
    r = $urandom(32'hb726d5ce);
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 16; i++) try(32'h1180 | i);
    $display("codes done");
    foreach (cs[k]) try(cs[k]);
    $display("corners done");
    repeat (200) try($urandom & 32'hf_ffff);
    ahb(1'b0, srsd_pkg::OFS_COUNT, 32'h0, r);
    chk_word(r, n_ill);
    ahb(1'b1, srsd_pkg::OFS_COUNT, 32'h0, r);
    ahb(1'b0, srsd_pkg::OFS_COUNT, 32'h0, r);
    chk_word(r, 32'h0);
    ahb(1'b0, 12'h00c, 32'h0, r);
    chk_word(r, 32'h0);
    $display("count done");
    test_done();
  end
endmodule // tb_source_region_stride_decode
